// [cmo_cache_ops.sv]
// Cache maintenance operation sequencer for the primary caches.
`timescale 1ns/10ps
`include "cmo_cfg.svh"
module cmo_cache_ops (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Issue side from the pipeline.
	input  wire logic        op_valid_in,
	input  wire logic [4:0]  op_field_in,
	input  wire logic [63:0] base_in,
	input  wire logic [15:0] offset_in,
	input  wire logic        older_graduated_in,
	input  wire logic        mem_idle_in,
	input  wire logic        addr_legal_in,
	input  wire logic        big_endian_in,
	input  wire logic [7:0]  address_space_tag_in,
	output logic             op_busy_out,
	output logic             op_done_out,
	output logic             addr_error_out,
	output logic             tlb_refill_out,
	output logic             tlb_invalid_out,
	output logic             mem_sync_out,
	// Translation unit.
	output logic [63:0]      xlate_vaddr_out,
	output logic             xlate_req_out,
	input  wire logic        xlate_done_in,
	input  wire logic [39:0] xlate_paddr_in,
	input  wire logic        xlate_miss_in,
	input  wire logic        xlate_inval_in,
	// Holding registers, written by software moves.
	input  wire logic        tag_high_wr_in,
	input  wire logic        tag_low_wr_in,
	input  wire logic        data_high_wr_in,
	input  wire logic        data_low_wr_in,
	input  wire logic [63:0] reg_wdata_in,
	output logic [31:0]      tag_high_reg_out,
	output logic [63:0]      tag_low_reg_out,
	output logic [63:0]      data_high_reg_out,
	output logic [63:0]      data_low_reg_out,
	// Cache array port.
	output logic             arr_req_out,
	output logic             arr_dcache_out,
	output logic [2:0]       arr_op_out,
	output logic             arr_debug_out,
	output logic             arr_write_out,
	output logic [7:0]       arr_set_out,
	output logic [1:0]       arr_way_out,
	output logic [1:0]       arr_dword_out,
	output logic [63:0]      arr_hit_addr_out,
	output logic [7:0]       arr_hit_address_space_tag_out,
	output logic [63:0]      arr_tag_lo_out,
	output logic [31:0]      arr_tag_hi_out,
	output logic [7:0]       arr_lru_out,
	output logic [63:0]      arr_data_lo_out,
	output logic [63:0]      arr_data_hi_out,
	input  wire logic        arr_ack_in,
	input  wire logic [63:0] arr_tag_lo_in,
	input  wire logic [31:0] arr_tag_hi_in,
	input  wire logic [63:0] arr_data_lo_in,
	input  wire logic [63:0] arr_data_hi_in
);

	typedef struct packed {
		cmo_pkg::cmo_state_t st;
		logic [2:0]  op;
		logic [1:0]  tgt;
		logic [63:0] ea;
		logic [39:0] pa;
		logic        dbe;
		logic [3:0]  cnt;
		logic        done;
		logic        aerr;
		logic        trefill;
		logic        tinval;
		logic [31:0] th;
		logic [63:0] tl;
		logic [63:0] dh;
		logic [63:0] dl;
	} cmo_regs_t;

	cmo_regs_t r_q;
	cmo_regs_t r_d;

	logic        is_hit;
	logic        is_dc;
	logic        is_dbg;
	logic        supported;
	logic [7:0]  lru_sel;
	logic [63:0] ea_calc;

	// Decoding is purely from the latched field so it stays stable during the access.
	always_comb begin
		is_dc  = r_q.tgt[0];
		is_dbg = r_q.tgt[1];
		is_hit = !is_dbg && r_q.op[2];
		case (r_q.op)
			`CMO_OP_IDX_INV:  supported = !is_dbg;
			`CMO_OP_IDX_LTAG: supported = 1'b1;
			`CMO_OP_IDX_STAG: supported = 1'b1;
			`CMO_OP_HIT_INV:  supported = !is_dbg;
			`CMO_OP_HIT_WBI:  supported = r_q.tgt == `CMO_TGT_DC;
			`CMO_OP_HIT_WB:   supported = r_q.tgt == `CMO_TGT_DC;
			default:          supported = 1'b0;
		endcase
	end

	// The sum simply wraps at 64 bits, and the low bits are never checked for alignment.
	// effective address is base plus sign-extended offset
	assign ea_calc = base_in + {{48{offset_in[15]}}, offset_in};

	// An all-zero field names no way order, so it is treated as invalid.
	// flagged and valid replacement value, else default
	always_comb begin
		lru_sel = `CMO_LRU_DEFAULT;
		if (r_q.th[`CMO_TH_LU] &&
			r_q.th[`CMO_TH_LRU_HI:`CMO_TH_LRU_LO] != 8'h00) begin
			lru_sel = r_q.th[`CMO_TH_LRU_HI:`CMO_TH_LRU_LO];
		end
	end

	// Next-state logic for the whole block.
	// One operation is in flight at a time; an issue is only looked at in the idle state,
	// so an issue pulse that arrives while busy is simply dropped.
	// The leading and trailing sync only cover loads and stores: instruction fetch is not
	// held back, so software must keep cache operations away from its own fetch path.
	always_comb begin
		r_d      = r_q;
		r_d.done = 1'b0;
		// Software moves into holding registers; a tag or data load acked in the same cycle overrides them.
		if (tag_high_wr_in) begin
			r_d.th = reg_wdata_in[31:0];
		end
		if (tag_low_wr_in) begin
			r_d.tl = reg_wdata_in;
		end
		if (data_high_wr_in) begin
			r_d.dh = reg_wdata_in;
		end
		if (data_low_wr_in) begin
			r_d.dl = reg_wdata_in;
		end
		case (r_q.st)
			cmo_pkg::CMO_IDLE: begin
				if (op_valid_in) begin
					r_d.op      = op_field_in[4:2];
					r_d.tgt     = op_field_in[1:0];
					// no alignment check on the address
					r_d.ea      = ea_calc;
					r_d.dbe     = big_endian_in;
					r_d.aerr    = 1'b0;
					r_d.trefill = 1'b0;
					r_d.tinval  = 1'b0;
					r_d.st      = cmo_pkg::CMO_DRAIN;
				end
			end
			cmo_pkg::CMO_DRAIN: begin
				// wait for graduation and memory sync before acting
				if (older_graduated_in && mem_idle_in) begin
					// address error only from mode legality
					if (!addr_legal_in) begin
						r_d.aerr = 1'b1;
						r_d.cnt  = `CMO_SYNC_CYCLES;
						r_d.st   = cmo_pkg::CMO_SYNC;
					end else if (!supported) begin
						r_d.cnt = `CMO_SYNC_CYCLES;
						r_d.st  = cmo_pkg::CMO_SYNC;
					end else if (is_hit || !is_dc) begin
						r_d.st = cmo_pkg::CMO_ACCESS;
					end else begin
						r_d.st = cmo_pkg::CMO_WRITE;
					end
				end
			end
			cmo_pkg::CMO_ACCESS: begin
				if (xlate_done_in) begin
					r_d.pa = xlate_paddr_in;
					if (is_dc && (xlate_miss_in || xlate_inval_in)) begin
						// data hit forms raise translation faults
						r_d.trefill = xlate_miss_in;
						r_d.tinval  = xlate_inval_in && !xlate_miss_in;
						r_d.cnt     = `CMO_SYNC_CYCLES;
						r_d.st      = cmo_pkg::CMO_SYNC;
					end else begin
						r_d.st = cmo_pkg::CMO_WRITE;
					end
				end
			end
			cmo_pkg::CMO_WRITE: begin
				if (arr_ack_in) begin
					if (r_q.op == `CMO_OP_IDX_LTAG) begin
						if (is_dbg) begin
							// instructions low, parity and predecode high
							r_d.dl = arr_data_lo_in;
							r_d.dh = arr_data_hi_in;
						end else begin
							// copy tag and set the update flag
							r_d.tl = arr_tag_lo_in;
							r_d.th = arr_tag_hi_in;
							r_d.th[`CMO_TH_LU] = 1'b1;
						end
					end
					r_d.cnt = `CMO_SYNC_CYCLES;
					r_d.st  = cmo_pkg::CMO_SYNC;
				end
			end
			cmo_pkg::CMO_SYNC: begin
				// trailing sync before the next operation
				if (r_q.cnt == 4'h0) begin
					r_d.done = 1'b1;
					r_d.st   = cmo_pkg::CMO_IDLE;
				end else begin
					r_d.cnt = r_q.cnt - 4'h1;
				end
			end
			default: begin
				r_d.st = cmo_pkg::CMO_IDLE;
			end
		endcase
	end

	// State register; async reset loads constants only.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// Pipeline-facing status.
	assign op_busy_out     = r_q.st != cmo_pkg::CMO_IDLE;
	assign op_done_out     = r_q.done;
	// no watchpoint output exists for these addresses
	assign addr_error_out  = r_q.done && r_q.aerr;
	// only refill and invalid faults, never modified-page
	assign tlb_refill_out  = r_q.done && r_q.trefill;
	assign tlb_invalid_out = r_q.done && r_q.tinval;
	assign mem_sync_out    = r_q.st == cmo_pkg::CMO_DRAIN || r_q.st == cmo_pkg::CMO_SYNC;
	assign xlate_vaddr_out = r_q.ea;
	assign xlate_req_out   = r_q.st == cmo_pkg::CMO_ACCESS;

	assign tag_high_reg_out  = r_q.th;
	assign tag_low_reg_out   = r_q.tl;
	assign data_high_reg_out = r_q.dh;
	assign data_low_reg_out  = r_q.dl;

	// Array command from the latched registers; the hit address space tag passes straight from address_space_tag_in.
	assign arr_req_out    = r_q.st == cmo_pkg::CMO_WRITE;
	assign arr_dcache_out = is_dc;
	assign arr_op_out     = r_q.op;
	assign arr_debug_out  = is_dbg;
	// invalidates and stores write the array
	assign arr_write_out  = r_q.op != `CMO_OP_IDX_LTAG;
	// set and way from the effective address
	assign arr_set_out    = r_q.ea[`CMO_SET_HI:`CMO_SET_LO];
	assign arr_way_out    = r_q.ea[`CMO_WAY_HI:`CMO_WAY_LO];
	assign arr_dword_out  = r_q.ea[`CMO_DW_HI:`CMO_DW_LO];
	// virtual for instruction side, physical for data side
	assign arr_hit_addr_out = is_dc ? {24'h000000, r_q.pa} : r_q.ea;
	assign arr_hit_address_space_tag_out = address_space_tag_in;
	assign arr_tag_lo_out   = r_q.tl;
	assign arr_tag_hi_out   = r_q.th;
	assign arr_lru_out      = lru_sel;
	// data words pass unswapped, predecode from data-high
	assign arr_data_lo_out  = r_q.dl;
	assign arr_data_hi_out  = r_q.dh;

	// no array access while the pipeline has not drained
	chk_serial_issue: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(arr_req_out) |-> $past(older_graduated_in) && $past(mem_idle_in))
		else $error("array access before drain");

	// update flag set after a tag read
	chk_tag_read_lu: assert property (@(posedge clk_in) disable iff (rst_in)
		arr_req_out && arr_ack_in && r_q.op == `CMO_OP_IDX_LTAG && !is_dbg
		|=> tag_high_reg_out[`CMO_TH_LU])
		else $error("update flag not set");

	// instruction side never reports translation faults
	chk_ic_no_tlb: assert property (@(posedge clk_in) disable iff (rst_in)
		op_done_out && !r_q.tgt[0] |-> !tlb_refill_out && !tlb_invalid_out)
		else $error("instruction op raised tlb fault");

	// data index forms never request translation
	chk_dc_idx_bypass: assert property (@(posedge clk_in) disable iff (rst_in)
		xlate_req_out |-> !(r_q.tgt[0] && !is_hit))
		else $error("data index op translated");

	// unsupported forms never reach the array
	chk_unsup_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
		arr_req_out |-> supported)
		else $error("unsupported op accessed array");

	chk_set_way: assert property (@(posedge clk_in) disable iff (rst_in)
		arr_req_out |-> arr_set_out == xlate_vaddr_out[12:5] && arr_way_out == r_q.ea[14:13])
		else $error("set or way mismatch");

	// an address error ends the op without any array access
	chk_addr_err: assert property (@(posedge clk_in) disable iff (rst_in)
		addr_error_out |-> !arr_req_out && !$past(arr_req_out, 4))
		else $error("address error after array access");

	// data hit fault ends the op within the sync window
	chk_dc_fault_done: assert property (@(posedge clk_in) disable iff (rst_in)
		xlate_req_out && xlate_done_in && r_q.tgt == `CMO_TGT_DC && xlate_miss_in
		|-> ##4 tlb_refill_out)
		else $error("data refill fault not reported");

	// refill wins over invalid when both are reported
	chk_fault_prio: assert property (@(posedge clk_in) disable iff (rst_in)
		tlb_refill_out |-> !tlb_invalid_out)
		else $error("refill and invalid faults together");

	// data index and debug forms end without translation faults
	chk_dc_idx_no_tlb: assert property (@(posedge clk_in) disable iff (rst_in)
		op_done_out && r_q.tgt[0] && !is_hit |-> !tlb_refill_out && !tlb_invalid_out)
		else $error("data index op raised tlb fault");

	// unflagged tag store loads the default replacement state
	chk_lru_default: assert property (@(posedge clk_in) disable iff (rst_in)
		arr_req_out && r_q.op == `CMO_OP_IDX_STAG && !is_dbg && !tag_high_reg_out[`CMO_TH_LU]
		|-> arr_lru_out == `CMO_LRU_DEFAULT)
		else $error("replacement default not used");

	// every array access is followed by the trailing sync
	chk_trail_sync: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(arr_req_out) |-> mem_sync_out && op_busy_out)
		else $error("no trailing sync after access");

	// tag and data reads never write the array
	chk_read_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
		arr_req_out && arr_op_out == `CMO_OP_IDX_LTAG |-> !arr_write_out)
		else $error("read op marked as array write");

	// the done pulse lasts one cycle only
	chk_done_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
		op_done_out |=> !op_done_out)
		else $error("done pulse longer than one cycle");

endmodule

// [cmo_cfg.svh]
// Constants for the cache maintenance operation block.
`ifndef CMO_CFG_SVH
`define CMO_CFG_SVH
`define CMO_TGT_IC      2'h0
`define CMO_TGT_DC      2'h1
`define CMO_TGT_IDBG    2'h2
`define CMO_TGT_DDBG    2'h3
`define CMO_OP_IDX_INV  3'h0
`define CMO_OP_IDX_LTAG 3'h1
`define CMO_OP_IDX_STAG 3'h2
`define CMO_OP_HIT_INV  3'h4
`define CMO_OP_HIT_WBI  3'h5
`define CMO_OP_HIT_WB   3'h6
`define CMO_SET_HI      12
`define CMO_SET_LO      5
`define CMO_WAY_HI      14
`define CMO_WAY_LO      13
`define CMO_DW_HI       4
`define CMO_DW_LO       3
`define CMO_TH_V        29
`define CMO_TH_P        27
`define CMO_TH_LU       22
`define CMO_TH_LRU_HI   21
`define CMO_TH_LRU_LO   14
`define CMO_TL_P1       11
`define CMO_TL_P0       10
`define CMO_TL_ADDRESS_SPACE_TAG_HI  7
`define CMO_TL_ADDRESS_SPACE_TAG_LO  0
`define CMO_LRU_DEFAULT 8'he4
`define CMO_SYNC_CYCLES 4'h2
`endif

// [cmo_pkg.sv]
// Types for the cache maintenance operation block.
package cmo_pkg;
	typedef enum logic [2:0] {
		CMO_IDLE,
		CMO_DRAIN,
		CMO_ACCESS,
		CMO_WRITE,
		CMO_SYNC
	} cmo_state_t;
endpackage

// [cmo_far_model.sv]
// Far-side model: translation unit and cache arrays with adjustable answer latency.
`timescale 1ns/10ps
module cmo_far_model (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Behaviour chosen by the bench.
	input  wire logic [1:0]  dly_in,
	input  wire logic        miss_in,
	input  wire logic        inval_in,
	input  wire logic [39:0] pa_in,
	input  wire logic [31:0] th_in,
	input  wire logic [63:0] tl_in,
	input  wire logic [63:0] dl_in,
	// Translation side.
	input  wire logic        xreq_in,
	output logic             xdone_out,
	output logic [39:0]      xpa_out,
	output logic             xmiss_out,
	output logic             xinval_out,
	// Array side.
	input  wire logic        areq_in,
	output logic             aack_out,
	output logic [31:0]      ath_out,
	output logic [63:0]      atl_out,
	output logic [63:0]      adl_out,
	output logic [63:0]      adh_out
);
	logic [1:0] xc_q;
	logic [1:0] ac_q;
	logic [7:0] flip_q;

	// Wait counters; the churning pattern stops stale answers from looking valid.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			xc_q   <= 2'h0;
			ac_q   <= 2'h0;
			flip_q <= 8'h5a;
		end else begin
			xc_q   <= (xreq_in && !xdone_out) ? xc_q + 2'h1 : 2'h0;
			ac_q   <= (areq_in && !aack_out) ? ac_q + 2'h1 : 2'h0;
			flip_q <= ~flip_q + 8'h13;
		end
	end

	assign xdone_out  = xreq_in && (xc_q == dly_in);
	assign xpa_out    = xdone_out ? pa_in : {5{flip_q}};
	assign xmiss_out  = xdone_out ? miss_in : flip_q[0];
	assign xinval_out = xdone_out ? inval_in : flip_q[1];
	assign aack_out   = areq_in && (ac_q == dly_in);
	assign ath_out    = aack_out ? th_in : {4{flip_q}};
	assign atl_out    = aack_out ? tl_in : {8{flip_q}};
	assign adl_out    = aack_out ? dl_in : {8{~flip_q}};
	assign adh_out    = aack_out ? ~dl_in : {8{flip_q}};
endmodule

// [test_cmo_cache_ops.sv]
// Self-checking bench for the cache maintenance operation sequencer.
`timescale 1ns/10ps
module test_cmo_cache_ops;
	typedef struct {
		logic        arr, xk, xl, wr;
		logic [4:0]  f;
		logic [7:0]  st, lru;
		logic [1:0]  wy, dw, k;
		logic [2:0]  fl;
		logic [63:0] ha, tl, dl, dh, ea;
		logic [31:0] th;
	} cmo_note_t;
	logic        clk_in, rst_in, op_valid_in, older_graduated_in, mem_idle_in, addr_legal_in;
	logic        big_endian_in, tag_high_wr_in, tag_low_wr_in, data_high_wr_in, data_low_wr_in;
	logic        op_busy_out, op_done_out, addr_error_out, tlb_refill_out, tlb_invalid_out;
	logic        mem_sync_out, xlate_req_out, xlate_done_in, xlate_miss_in, xlate_inval_in;
	logic        arr_req_out, arr_dcache_out, arr_debug_out, arr_write_out, arr_ack_in;
	logic        miss, inv, a_seen, x_seen;
	logic [4:0]  op_field_in;
	logic [15:0] offset_in;
	logic [7:0]  address_space_tag_in, arr_set_out, arr_hit_address_space_tag_out, arr_lru_out;
	logic [2:0]  arr_op_out;
	logic [1:0]  arr_way_out, arr_dword_out, dly;
	logic [39:0] xlate_paddr_in, pa;
	logic [31:0] tag_high_reg_out, arr_tag_hi_out, arr_tag_hi_in, eth, mth;
	logic [63:0] base_in, reg_wdata_in, xlate_vaddr_out, tag_low_reg_out, data_high_reg_out;
	logic [63:0] data_low_reg_out, arr_hit_addr_out, arr_tag_lo_out, arr_data_lo_out;
	logic [63:0] arr_data_hi_out, arr_tag_lo_in, arr_data_lo_in, arr_data_hi_in;
	logic [63:0] etl, edl, edh, mtl, mdl, v;
	cmo_note_t   notes[$];
	cmo_note_t   cur;
	int          n_fail, checks;

	cmo_cache_ops i_cmo_cache_ops (.clk_in, .rst_in, .op_valid_in, .op_field_in, .base_in,
		.offset_in, .older_graduated_in, .mem_idle_in, .addr_legal_in, .big_endian_in,
		.address_space_tag_in, .op_busy_out, .op_done_out, .addr_error_out, .tlb_refill_out,
		.tlb_invalid_out, .mem_sync_out, .xlate_vaddr_out, .xlate_req_out, .xlate_done_in,
		.xlate_paddr_in, .xlate_miss_in, .xlate_inval_in, .tag_high_wr_in, .tag_low_wr_in,
		.data_high_wr_in, .data_low_wr_in, .reg_wdata_in, .tag_high_reg_out, .tag_low_reg_out,
		.data_high_reg_out, .data_low_reg_out, .arr_req_out, .arr_dcache_out, .arr_op_out,
		.arr_debug_out, .arr_write_out, .arr_set_out, .arr_way_out, .arr_dword_out,
		.arr_hit_addr_out, .arr_hit_address_space_tag_out, .arr_tag_lo_out, .arr_tag_hi_out, .arr_lru_out,
		.arr_data_lo_out, .arr_data_hi_out, .arr_ack_in, .arr_tag_lo_in, .arr_tag_hi_in,
		.arr_data_lo_in, .arr_data_hi_in);

	cmo_far_model i_cmo_far_model (.clk_in(clk_in), .rst_in(rst_in), .dly_in(dly),
		.miss_in(miss), .inval_in(inv), .pa_in(pa), .th_in(mth), .tl_in(mtl), .dl_in(mdl),
		.xreq_in(xlate_req_out), .xdone_out(xlate_done_in), .xpa_out(xlate_paddr_in),
		.xmiss_out(xlate_miss_in), .xinval_out(xlate_inval_in), .areq_in(arr_req_out),
		.aack_out(arr_ack_in), .ath_out(arr_tag_hi_in), .atl_out(arr_tag_lo_in),
		.adl_out(arr_data_lo_in), .adh_out(arr_data_hi_in));

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task complete_run;
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Array commands are checked at the ack, results and faults at the done pulse.
	always @(posedge clk_in) begin
		if (!rst_in) begin
			chk("order", 0, arr_req_out && !(older_graduated_in && mem_idle_in));
			if (op_busy_out && !older_graduated_in)
				chk("sync", 1, mem_sync_out);
			if (xlate_req_out && xlate_done_in)
				x_seen <= 1'b1;
			if (xlate_req_out && xlate_done_in && notes.size() > 0)
				chk("xlate_vaddr", notes[0].ea, xlate_vaddr_out);
			if (arr_req_out && arr_ack_in && notes.size() > 0) begin
				cur = notes[0];
				a_seen <= 1'b1;
				chk("cmd", cur.f, {arr_op_out, arr_debug_out, arr_dcache_out});
				chk("set", cur.st, arr_set_out);
				chk("way", cur.wy, arr_way_out);
				chk("write", cur.wr, arr_write_out);
				if (cur.k == 2'h1) begin
					chk("lru", cur.lru, arr_lru_out);
					chk("tag_hi", cur.th, arr_tag_hi_out);
					chk("tag_lo", cur.tl, arr_tag_lo_out);
				end
				if (cur.k == 2'h2)
					chk("dword", cur.dw, arr_dword_out);
				if (cur.k == 2'h2 && cur.wr)
					chk("data_lo", cur.dl, arr_data_lo_out);
				if (cur.k == 2'h2 && cur.wr)
					chk("data_hi", cur.dh, arr_data_hi_out);
				if (cur.k == 2'h3)
					chk("hit_addr", cur.ha, arr_hit_addr_out);
				if (cur.k == 2'h3 && !cur.f[0])
					chk("hit_address_space_tag", address_space_tag_in, arr_hit_address_space_tag_out);
			end
			if (op_done_out) begin
				a_seen <= 1'b0;
				x_seen <= 1'b0;
				if (notes.size() == 0)
					chk("spare_done", 0, 1);
				else begin
					cur = notes.pop_front();
					chk("array_used", cur.arr, a_seen);
					if (cur.xk)
						chk("xlate_used", cur.xl, x_seen);
					chk("faults", cur.fl, {addr_error_out, tlb_refill_out, tlb_invalid_out});
					chk("tag_high_reg", cur.th, tag_high_reg_out);
					chk("tag_low_reg", cur.tl, tag_low_reg_out);
					chk("data_low_reg", cur.dl, data_low_reg_out);
					chk("data_high_reg", cur.dh, data_high_reg_out);
					chk("busy", 0, op_busy_out);
				end
			end
		end
	end

	task automatic put(input int s, input logic [63:0] d);
		@(posedge clk_in);
		{tag_high_wr_in, tag_low_wr_in, data_high_wr_in, data_low_wr_in} <= 4'h8 >> s;
		reg_wdata_in <= d;
		@(posedge clk_in);
		{tag_high_wr_in, tag_low_wr_in, data_high_wr_in, data_low_wr_in} <= 4'h0;
	endtask

	task automatic run_op(input logic [4:0] f);
		logic [63:0] b;
		logic [63:0] ea;
		logic [15:0] o;
		logic        sup;
		logic        lg;
		logic        df;
		cmo_note_t   q;
		int          i;
		@(posedge clk_in);
		{mth, mtl, mdl} <= {$urandom, $urandom, $urandom, $urandom, $urandom};
		{pa, miss, inv, dly} <= 44'({$urandom, $urandom});
		@(posedge clk_in);
		b = {$urandom, $urandom};
		o = 16'($urandom);
		ea = b + {{48{o[15]}}, o};
		sup = f[1] ? f[4:2] inside {3'h1, 3'h2} : f[0] ? f[4:2] inside {[0:2], [4:6]} :
			f[4:2] inside {[0:2], 3'h4};
		lg = !sup || $urandom_range(5) != 0;
		df = sup && lg && f[1:0] == 2'h1 && f[4] && (miss || inv);
		q.f = f;
		q.ea = ea;
		q.arr = sup && lg && !df;
		q.xk = sup && lg && !f[1];
		q.xl = !f[0] || f[4];
		{q.wy, q.st, q.dw} = ea[14:3];
		q.wr = f[4:2] != 3'h1;
		q.k = f[4] ? 2'h3 : f[1] ? 2'h2 : {1'b0, f[4:2] == 3'h2};
		q.fl = !lg ? 3'h4 : df ? (miss ? 3'h2 : 3'h1) : 3'h0;
		q.ha = f[0] ? {24'h0, pa} : ea;
		q.lru = (eth[22] && eth[21:14] != 8'h0) ? eth[21:14] : 8'he4;
		if (q.arr && f[4:2] == 3'h1 && f[1]) begin
			edl = mdl;
			edh = ~mdl;
		end
		if (q.arr && f[4:2] == 3'h1 && !f[1]) begin
			eth = mth | 32'h0040_0000;
			etl = mtl;
		end
		{q.th, q.tl, q.dl, q.dh} = {eth, etl, edl, edh};
		notes.push_back(q);
		{op_valid_in, op_field_in, base_in, offset_in, addr_legal_in} <= {1'b1, f, b, o, lg};
		{big_endian_in, address_space_tag_in} <= 9'($urandom);
		{older_graduated_in, mem_idle_in} <= 2'($urandom);
		i = 0;
		do begin
			@(posedge clk_in);
			op_valid_in <= (i == 1);
			if (i == 2)
				{older_graduated_in, mem_idle_in} <= 2'h3;
			@(negedge clk_in);
			i++;
		end while (op_done_out !== 1'b1 && i < 300);
		if (i >= 300) begin
			n_fail++;
			complete_run;
		end
	endtask

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		complete_run;
	end

	// Every code of every target, with fresh holding registers before each operation.
	initial begin
		{rst_in, op_valid_in, op_field_in, base_in, offset_in, addr_legal_in} = {1'b1, 87'h0};
		{older_graduated_in, mem_idle_in, big_endian_in, address_space_tag_in} = 11'h0;
		{tag_high_wr_in, tag_low_wr_in, data_high_wr_in, data_low_wr_in, reg_wdata_in} = 68'h0;
		{dly, miss, inv, pa, mth, mtl, mdl, a_seen, x_seen} = 206'h0;
		{eth, etl, edl, edh, n_fail, checks} = 288'h0;
		void'($urandom(32'hbf062459));
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			for (int f = 0; f < 32; f++) begin
				v = {$urandom, $urandom};
				if (r[0])
					v[21:14] = 8'h0;
				put(0, v);
				eth = v[31:0];
				put(1, ~v);
				etl = ~v;
				v = {$urandom, $urandom};
				put(2, v);
				edh = v;
				v = {$urandom, $urandom};
				put(3, v);
				edl = v;
				run_op(5'(f));
			end
		end
		complete_run;
	end
endmodule
